// ===== mtt_seq.sv
// Purpose: times moves between off, standby, config, receive and transmit
// Assumes: request inputs are synchronous; config_request_n is a pin
//          preamble_cycles is held steady while a move runs
// Notes:   each transition runs a list of phases, one delay per phase
//          outputs are registered, so status trails the mode register by a cycle
`timescale 1ns/1ps
`default_nettype none
module mtt_seq
    import mtt_pkg::*;
#(
    parameter int XTAL_CYCLES  = XTAL_CYC,
    parameter int SHORT_CYCLES = LOCK_SHORT_CYC,
    parameter int FULL_CYCLES  = LOCK_FULL_CYC,
    parameter int ONOFF_CYCLES = ONOFF_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  config_request_n,
    input  wire mtt_pkg::mtt_req_type  req,
    input  wire logic [CNT_W-1:0]      preamble_cycles,
    output var  mtt_pkg::mtt_stat_type stat,
    output var  logic                  xtal_on,
    output var  logic                  pll_on,
    output var  logic                  rx_on
);
    // Delay phases; idle means no counter runs
    typedef enum logic [2:0] {
        PH_IDLE  = 3'h0,
        PH_XTAL  = 3'h1,
        PH_PLL   = 3'h2,
        PH_PRE   = 3'h3,
        PH_ONOFF = 3'h4
    } mtt_phase_type;

    logic          cfg_s1_q;
    logic          cfg_s2_q;
    mtt_mode_type  mode_q;
    mtt_mode_type  tgt_q;
    mtt_phase_type ph_q;
    mtt_phase_type ph_d;
    mtt_pll_type   pll_q;
    logic          load_q;
    logic [CNT_W-1:0] len_q;
    logic [CNT_W-1:0] len_d;
    logic          done;

    // Two flops: config request comes from the host's pin
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_s1_q <= 1'b1;
            cfg_s2_q <= 1'b1;
        end else begin
            cfg_s1_q <= config_request_n;
            cfg_s2_q <= cfg_s1_q;
        end
    end

    wire cfg_low  = !cfg_s2_q;
    wire active   = (mode_q == MTT_RX) || (mode_q == MTT_TX);
    // Low config request ends rx or tx at once, even while the receiver winds down, except during a move between rx and tx
    wire abort    = cfg_low && active && (ph_q == PH_IDLE || ph_q == PH_ONOFF);
    wire from_cfg = (mode_q == MTT_CONFIG);
    // A move is taken only between moves; a request while busy waits
    wire start    = (ph_q == PH_IDLE) && req.valid && (req.target != mode_q) && !abort;

    // PLL delay picked from the lock status held before configuration
    function automatic logic [CNT_W-1:0] lock_len(mtt_pll_type s);
        logic [CNT_W-1:0] n;
        case (s)
            MTT_PLL_LOCKED: n = '0;
            MTT_PLL_SHORT:  n = CNT_W'(SHORT_CYCLES);
            default:        n = CNT_W'(FULL_CYCLES);
        endcase
        return n;
    endfunction

    wire [CNT_W-1:0] pll_len = lock_len(pll_q);

    function automatic mtt_phase_type first_phase(mtt_mode_type from, mtt_mode_type to);
        if (to == MTT_CONFIG && from == MTT_STANDBY)
            return PH_XTAL;
        else if (to == MTT_RX && from == MTT_CONFIG)
            return PH_PLL;
        else if (to == MTT_RX)
            return PH_XTAL;
        else if (to == MTT_TX)
            return PH_PLL;
        else if (from == MTT_RX)
            return PH_ONOFF;
        else
            return PH_IDLE;
    endfunction

    // Phase after the current one finishes; idle means arrive at target
    function automatic mtt_phase_type next_phase(mtt_phase_type p, mtt_mode_type to);
        mtt_phase_type n;
        n = PH_IDLE;
        if (to == MTT_RX) begin
            case (p)
                PH_XTAL: n = PH_PLL;
                PH_PLL:  n = PH_PRE;
                default: n = PH_IDLE;
            endcase
        end
        return n;
    endfunction

    wire mtt_phase_type nxt = next_phase(ph_q, tgt_q);
    wire mtt_phase_type fst = first_phase(mode_q, req.target);
    // Mode reached by the move that completes in this cycle
    wire mtt_mode_type  dest = start ? req.target : tgt_q;

    always_comb begin
        ph_d = ph_q;
        if (start) begin
            ph_d = fst;
        end else if (ph_q != PH_IDLE && done && !abort) begin
            ph_d = nxt;
        end
    end

    // Each phase loads its own limit, so a move sums only its phases
    always_comb begin
        case (ph_d)
            PH_XTAL:  len_d = CNT_W'(XTAL_CYCLES);
            PH_PLL:   len_d = from_cfg ? pll_len : CNT_W'(FULL_CYCLES);
            PH_PRE:   len_d = preamble_cycles;
            PH_ONOFF: len_d = CNT_W'(ONOFF_CYCLES);
            default:  len_d = '0;
        endcase
    end

    // A new delay is loaded whenever a phase begins
    wire phase_change = (ph_d != PH_IDLE) && (start || (done && ph_q != PH_IDLE));
    // Arrival: a zero-delay move, or the end of the last phase
    wire arrive = (start && ph_d == PH_IDLE) || (ph_q != PH_IDLE && done && nxt == PH_IDLE);

    // One counter serves every phase; phases never overlap
    mtt_delay #(
        .W(CNT_W)
    ) u_delay (
        .clk   (clk),
        .rst   (rst),
        .load  (load_q),
        .len   (len_q),
        .abort (abort),
        .done  (done)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            load_q <= 1'b0;
            len_q  <= '0;
        end else begin
            load_q <= phase_change && !abort;
            len_q  <= len_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= mtt_mode_type'(STATE_RST);
            tgt_q  <= MTT_OFF;
            ph_q   <= PH_IDLE;
        end else if (abort) begin
            mode_q <= MTT_CONFIG;
            ph_q   <= PH_IDLE;
        end else begin
            ph_q <= ph_d;
            if (start) begin
                tgt_q <= req.target;
            end
            if (arrive) begin
                mode_q <= dest;
            end
        end
    end

    // Lock status is kept through configuration; it times the move out of it
    always_ff @(posedge clk) begin
        if (rst) begin
            pll_q <= MTT_PLL_COLD;
        end else if (arrive && !abort) begin
            if (dest == MTT_RX || dest == MTT_TX) begin
                pll_q <= MTT_PLL_LOCKED;
            end else if (dest != MTT_CONFIG) begin
                pll_q <= MTT_PLL_COLD;
            end
        end
    end

    // Crystal is off in off and standby, except while a move is under way
    always_ff @(posedge clk) begin
        if (rst) begin
            stat.mode <= MTT_OFF;
            stat.busy <= 1'b0;
            xtal_on   <= 1'b0;
            pll_on    <= 1'b0;
            rx_on     <= 1'b0;
        end else begin
            stat.mode <= mode_q;
            stat.busy <= (ph_q != PH_IDLE);
            xtal_on   <= (mode_q == MTT_CONFIG) || active || (ph_q != PH_IDLE);
            pll_on    <= active || (ph_q == PH_PLL) || (ph_q == PH_PRE);
            rx_on     <= (mode_q == MTT_RX);
        end
    end
endmodule
`default_nettype wire

// ===== mtt_pkg.sv
// Purpose: shared constants and types for the mode transition timer
// Assumes: 40 MHz clock
// Notes:   durations kept in their own units, cycle counts derived here
package mtt_pkg;
    localparam int CLK_MHZ = 40;
    localparam int XTAL_US = 600;
    localparam int LOCK_SHORT_US = 30;
    localparam int LOCK_FULL_US = 50;
    localparam int ONOFF_US = 100;
    localparam int XTAL_CYC = XTAL_US * CLK_MHZ;
    localparam int LOCK_SHORT_CYC = LOCK_SHORT_US * CLK_MHZ;
    localparam int LOCK_FULL_CYC = LOCK_FULL_US * CLK_MHZ;
    localparam int ONOFF_CYC = ONOFF_US * CLK_MHZ;
    localparam int CNT_W = 24;
    localparam logic [2:0] STATE_RST = 3'h0;

    typedef enum logic [2:0] {
        MTT_OFF     = 3'h0,
        MTT_STANDBY = 3'h1,
        MTT_CONFIG  = 3'h2,
        MTT_RX      = 3'h3,
        MTT_TX      = 3'h4
    } mtt_mode_type;

    typedef enum logic [1:0] {
        MTT_PLL_COLD  = 2'h0,
        MTT_PLL_SHORT = 2'h1,
        MTT_PLL_LOCKED = 2'h2
    } mtt_pll_type;

    // Request from the mode logic: wanted target and whether it is allowed now
    typedef struct packed {
        logic         valid;
        mtt_mode_type target;
    } mtt_req_type;

    typedef struct packed {
        mtt_mode_type mode;
        logic         busy;
    } mtt_stat_type;
endpackage

// ===== mtt_delay.sv
// Purpose: one-shot delay counter
// Assumes: load pulse with length in cycles; zero length finishes next cycle
// Notes:   done is a one-cycle pulse from a register
`timescale 1ns/1ps
`default_nettype none
module mtt_delay #(
    parameter int W = 24
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] len,
    input  wire logic         abort,
    output var  logic         done
);
    logic [W-1:0] cnt_q;
    logic         run_q;
    wire          last = run_q && (cnt_q <= W'(1));

    always_ff @(posedge clk) begin
        if (rst || abort) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done  <= 1'b0;
        end else if (load) begin
            cnt_q <= len;
            run_q <= 1'b1;
            done  <= 1'b0;
        end else begin
            cnt_q <= run_q ? cnt_q - W'(1) : cnt_q;
            run_q <= run_q && !last;
            done  <= last;
        end
    end
endmodule
`default_nettype wire

// ===== mtt_seq_sva.sv
// Purpose: timing checks for mtt_seq
// Assumes: req held until it arrives
// Notes:   slack covers phase overhead
`timescale 1ns/1ps
`default_nettype none
module mtt_seq_sva
    import mtt_pkg::*;
#(parameter int XTAL_CYCLES = 1, FULL_CYCLES = 1, ONOFF_CYCLES = 1) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  config_request_n,
    input wire mtt_pkg::mtt_req_type  req,
    input wire logic [CNT_W-1:0]      preamble_cycles,
    input wire mtt_pkg::mtt_stat_type stat
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    localparam int XT = XTAL_CYCLES, FU = FULL_CYCLES, ON = ONOFF_CYCLES;
    int w_q, rx_lo;
    assign rx_lo = XT + FU + int'(preamble_cycles);
    // Counts only while a request waits, so an early start shows as a short wait
    always_ff @(posedge clk) begin
        w_q <= (rst || !req.valid || req.target == stat.mode) ? 0 : w_q + 1;
    end
    property m(mtt_mode_type a, mtt_mode_type b, int lo, int hi);
        $past(stat.mode) == a && stat.mode == b |-> w_q >= lo && w_q <= hi;
    endproperty
    a_sb_cfg: assert property (m(MTT_STANDBY, MTT_CONFIG, XT, XT + 8)) else $error("sb cf");
    a_sb_rx: assert property (m(MTT_STANDBY, MTT_RX, rx_lo, rx_lo + 16)) else $error("sb rx");
    a_off_rx: assert property (m(MTT_OFF, MTT_RX, rx_lo, rx_lo + 16)) else $error("off rx");
    a_cf_rx: assert property (m(MTT_CONFIG, MTT_RX, rx_lo - XT - FU, rx_lo - XT + 12))
        else $error("cf rx");
    a_cf_tx: assert property (m(MTT_CONFIG, MTT_TX, 0, FU + 8)) else $error("cf tx");
    a_rx_sb: assert property (m(MTT_RX, MTT_STANDBY, ON, ON + 8)) else $error("rx sb");
    a_rx_off: assert property (m(MTT_RX, MTT_OFF, ON, ON + 8)) else $error("rx off");
    a_rx_abort: assert property ($fell(config_request_n) && stat.mode == MTT_RX
        |-> ##[1:6] stat.mode == MTT_CONFIG) else $error("rx abort");
    a_tx_abort: assert property ($fell(config_request_n) && stat.mode == MTT_TX
        |-> ##[1:6] stat.mode == MTT_CONFIG) else $error("tx abort");
    c_abort: cover property ($past(stat.mode) == MTT_RX && stat.mode == MTT_CONFIG);
    c_tx: cover property (stat.mode == MTT_TX);
    c_sb: cover property (stat.mode == MTT_STANDBY);
endmodule
bind mtt_seq mtt_seq_sva #(.XTAL_CYCLES(XTAL_CYCLES), .FULL_CYCLES(FULL_CYCLES),
    .ONOFF_CYCLES(ONOFF_CYCLES)) u_sva (.clk(clk), .rst(rst), .req(req), .stat(stat),
    .config_request_n(config_request_n), .preamble_cycles(preamble_cycles));
`default_nettype wire

// ===== mtt_host.sv
// Purpose: host side of the config request pin
// Assumes: bench says when to reprogram
// Notes:   pin idles high
`timescale 1ns/1ps
`default_nettype none
module mtt_host (
    input  wire logic clk,
    input  wire logic reprogram,
    output var  logic config_request_n = 1'b1
);
    // Lowered only to reprogram, since it cuts rx or tx off at once
    always @(posedge clk) config_request_n <= !reprogram;
endmodule
`default_nettype wire

// ===== mode_transition_timing_bench.sv
// Purpose: self-checking bench for mtt_seq
// Assumes: short delays, preamble 12
// Notes:   ranges allow phase overhead
`timescale 1ns/1ps
`default_nettype none
module mode_transition_timing_bench;
    import mtt_pkg::*;
    localparam int XT = 60, FU = 30, ON = 40, PRE = 12, RXI = XT + FU + PRE;
    logic clk = 1'b0, rst = 1'b1, reprogram = 1'b0, config_request_n;
    logic xtal_on, pll_on, rx_on;
    mtt_req_type req = '0;
    mtt_stat_type stat;
    int fail_count = 0, checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    mtt_host u_host (.clk(clk), .reprogram(reprogram), .config_request_n(config_request_n));
    mtt_seq #(.XTAL_CYCLES(XT), .SHORT_CYCLES(10), .FULL_CYCLES(FU), .ONOFF_CYCLES(ON)) u_dut (
        .clk(clk), .rst(rst), .config_request_n(config_request_n), .req(req),
        .preamble_cycles(24'(PRE)), .stat(stat), .xtal_on(xtal_on), .pll_on(pll_on),
        .rx_on(rx_on));
    // Expected crystal, PLL and receiver flags once a mode is reached
    function automatic logic [2:0] on_exp(input mtt_mode_type m);
        return {m != MTT_OFF && m != MTT_STANDBY, m == MTT_RX || m == MTT_TX, m == MTT_RX};
    endfunction
    // Abort through the host pin when ab is set, else a held request
    task automatic move(input mtt_mode_type t, input int lo, input int hi, input bit ab = 0);
        int n;
        int busy_n;
        logic [2:0] flags;
        busy_n = 0;
        @(negedge clk);
        req = mtt_req_type'{!ab, t};
        reprogram = ab;
        for (n = 0; stat.mode !== t && n < 400; n++) begin
            busy_n += int'(stat.busy === 1'b1);
            @(negedge clk);
        end
        flags = {xtal_on, pll_on, rx_on};
        req = '0;
        reprogram = 1'b0;
        checks++;
        if (n < lo || n > hi) begin
            fail_count++;
            $display("unexpected cycles to %s exp %0d..%0d seen %0d", t.name(), lo, hi, n);
        end
        checks++;
        if ((busy_n > 0) !== (lo > 8)) begin
            fail_count++;
            $display("unexpected busy to %s exp %0d seen %0d", t.name(), lo > 8, busy_n > 0);
        end
        checks++;
        if (flags !== on_exp(t)) begin
            fail_count++;
            $display("unexpected flags at %s exp %b seen %b", t.name(), on_exp(t), flags);
        end
        repeat (4) @(negedge clk);
    endtask
    task automatic t_standby_tx();
        move(MTT_STANDBY, 0, 6);
        move(MTT_CONFIG, XT, XT + 8);
        move(MTT_TX, FU, FU + 8);
        move(MTT_CONFIG, 1, 8, 1);
        $display("test standby_tx done");
    endtask
    task automatic t_rx_paths();
        move(MTT_RX, PRE, PRE + 8);
        move(MTT_CONFIG, 1, 8, 1);
        move(MTT_RX, PRE, PRE + 8);
        move(MTT_STANDBY, ON, ON + 8);
        move(MTT_RX, RXI, RXI + 16);
        move(MTT_OFF, ON, ON + 8);
        move(MTT_RX, RXI, RXI + 16);
        $display("test rx_paths done");
    endtask
    task automatic print_verdict(input int extra);
        fail_count += extra;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) if (++cyc == 2500) print_verdict(1);
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_standby_tx();
        t_rx_paths();
        print_verdict(0);
    end
endmodule
`default_nettype wire
